// ==== rtl/ppsm_pkg.sv ====
// Purpose: Shared constants and carriers for the dual parallel port block.
// Assumes: Byte-wide special register space with the port registers at their offsets.
// Notes:   Port B pin level and latch offsets are held here for the register decode.
package ppsm_pkg;

  localparam logic [11:0] PPSM_ADDR_PORT_A_LATCH  = 12'h001;
  localparam logic [11:0] PPSM_ADDR_PORT_B_LATCH  = 12'h002;
  localparam logic [11:0] PPSM_ADDR_PORT_A_LEVELS = 12'h008;
  localparam logic [11:0] PPSM_ADDR_PORT_B_LEVELS = 12'h009;
  localparam logic [11:0] PPSM_ADDR_PORT_A_SEGSEL = 12'h029;

  localparam logic [7:0] PPSM_PORT_A_LATCH_RESET  = 8'hFF;
  localparam logic [7:0] PPSM_PORT_A_SEGSEL_RESET = 8'h00;
  localparam logic [2:0] PPSM_PORT_B_LATCH_RESET  = 3'h7;

  localparam int PPSM_STOP_PIN_BIT = 0;

  // Register bus request of one CPU access.
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        rd_s1;
    logic        wr_s2;
  } ppsm_req_type;

  // Whole registered state of the port block.
  typedef struct packed {
    logic [7:0] port_a_output_latch;
    logic [7:0] port_a_segment_select;
    logic [2:0] port_b_output_latch;
    logic [7:0] rdata;
    logic       stop_pin_prev;
    logic       stop_edge;
  } ppsm_state_type;

endpackage

// ==== rtl/ppsm_ports.sv ====
// Purpose: Output latches and pin level reads for an 8-bit and a 3-bit port, with segment routing on the 8-bit port only.
// Assumes: The CPU strobes rd_s1 in the first state of a read cycle and wr_s2 in the
//          second state of a write cycle; all pin inputs are synchronous to ref_clk_i.
// Notes:   Pins are split into input, output and output enable.
`timescale 1ns/1ps
`default_nettype none
module ppsm_ports
  import ppsm_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [11:0] cpu_addr_i,
  input  wire logic [7:0]  cpu_wdata_i,
  input  wire logic        cpu_rd_s1_i,
  input  wire logic        cpu_wr_s2_i,
  output logic      [7:0]  cpu_rdata_o,
  input  wire logic [7:0]  port_a_pin_i,
  output logic      [7:0]  port_a_pin_o,
  output logic      [7:0]  port_a_pin_oe_o,
  input  wire logic [7:0]  segment_drive_i,
  input  wire logic [2:0]  port_b_pin_i,
  output logic      [2:0]  port_b_pin_o,
  output logic      [2:0]  port_b_pin_oe_o,
  input  wire logic        dual_clock_mode_i,
  input  wire logic        stop_mode_i,
  input  wire logic        output_drive_enable_i,
  input  wire logic        slow_crystal_output_i,
  output logic             slow_crystal_input_o,
  output logic             stop_release_level_o,
  output logic             stop_pin_fall_o
);

  ppsm_req_type   req;
  ppsm_state_type st;
  ppsm_state_type next_st;
  logic [2:0]     port_b_level;

  assign req = '{addr: cpu_addr_i, wdata: cpu_wdata_i, rd_s1: cpu_rd_s1_i, wr_s2: cpu_wr_s2_i};

  // The pad level is what the pin shows; a driven pin reflects its own drive.
  assign port_b_level = port_b_pin_i;

  always_comb begin
    next_st = st;
    next_st.stop_pin_prev = port_b_level[PPSM_STOP_PIN_BIT];
    // Edge taken from the pad, so an output pulse on the pin also sets the flag.
    next_st.stop_edge = st.stop_pin_prev & ~port_b_level[PPSM_STOP_PIN_BIT];
    if (req.wr_s2) begin
      if (req.addr == PPSM_ADDR_PORT_A_LATCH) begin
        next_st.port_a_output_latch = req.wdata;
      end else if (req.addr == PPSM_ADDR_PORT_A_SEGSEL) begin
        next_st.port_a_segment_select = req.wdata;
      end else if (req.addr == PPSM_ADDR_PORT_B_LATCH) begin
        next_st.port_b_output_latch = req.wdata[2:0];
      end
    end
    if (req.rd_s1) begin
      if (req.addr == PPSM_ADDR_PORT_A_LATCH) begin
        next_st.rdata = st.port_a_output_latch;
      end else if (req.addr == PPSM_ADDR_PORT_A_SEGSEL) begin
        next_st.rdata = st.port_a_segment_select;
      end else if (req.addr == PPSM_ADDR_PORT_A_LEVELS) begin
        next_st.rdata = port_a_pin_i;
      end else if (req.addr == PPSM_ADDR_PORT_B_LATCH) begin
        next_st.rdata = {5'h00, st.port_b_output_latch};
      end else if (req.addr == PPSM_ADDR_PORT_B_LEVELS) begin
        next_st.rdata = {5'h00, port_b_level};
      end else begin
        next_st.rdata = 8'h00;
      end
    end
    if (sys_rst_i) begin
      next_st.port_a_output_latch   = PPSM_PORT_A_LATCH_RESET;
      next_st.port_a_segment_select = PPSM_PORT_A_SEGSEL_RESET;
      next_st.port_b_output_latch   = PPSM_PORT_B_LATCH_RESET;
      next_st.rdata                 = 8'h00;
      next_st.stop_pin_prev         = 1'b1;
      next_st.stop_edge             = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    st <= next_st;
  end

  // Latch bit one means weak high release, so a pin not selected for a segment only drives a low.
  // One process drives the whole byte so that no bit has two drivers.
  always_comb begin
    port_a_pin_o    = st.port_a_output_latch;
    port_a_pin_oe_o = ~st.port_a_output_latch;
    for (int i = 0; i < 8; i++) begin
      if (st.port_a_segment_select[i]) begin
        port_a_pin_o[i]    = segment_drive_i[i];
        port_a_pin_oe_o[i] = 1'b1;
      end
    end
  end

  always_comb begin
    port_b_pin_o    = st.port_b_output_latch;
    port_b_pin_oe_o = ~st.port_b_output_latch & {3{output_drive_enable_i}};
    if (stop_mode_i) begin
      port_b_pin_oe_o[PPSM_STOP_PIN_BIT] = 1'b0;
    end
    if (dual_clock_mode_i) begin
      port_b_pin_o[2:1]    = {slow_crystal_output_i, 1'b0};
      port_b_pin_oe_o[2:1] = 2'b10;
    end
  end

  assign slow_crystal_input_o = port_b_pin_i[1];
  assign stop_release_level_o = port_b_pin_i[PPSM_STOP_PIN_BIT];
  assign stop_pin_fall_o      = st.stop_edge;
  assign cpu_rdata_o          = st.rdata;

  property p_reset_latch;
    @(posedge ref_clk_i) sys_rst_i |=>
      st.port_a_output_latch == PPSM_PORT_A_LATCH_RESET &&
      st.port_b_output_latch == PPSM_PORT_B_LATCH_RESET;
  endproperty
  a_reset_latch: assert property (p_reset_latch) else $error("latch reset wrong");

  property p_reset_b;
    @(posedge ref_clk_i) sys_rst_i |=> st.port_b_output_latch == PPSM_PORT_B_LATCH_RESET;
  endproperty
  a_reset_b: assert property (p_reset_b) else $error("port b latch reset wrong");

  property p_reset_seg;
    @(posedge ref_clk_i) sys_rst_i |=> st.port_a_segment_select == PPSM_PORT_A_SEGSEL_RESET;
  endproperty
  a_reset_seg: assert property (p_reset_seg) else $error("segment reset wrong");

  // Only pins left to the port logic must follow the written byte.
  property p_write_a;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cpu_wr_s2_i && cpu_addr_i == PPSM_ADDR_PORT_A_LATCH |=>
        ((port_a_pin_o ^ $past(cpu_wdata_i)) & ~st.port_a_segment_select) == 8'h00;
  endproperty
  a_write_a: assert property (p_write_a) else $error("port write lost");

  property p_write_seg;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cpu_wr_s2_i && cpu_addr_i == PPSM_ADDR_PORT_A_SEGSEL |=>
        st.port_a_segment_select == $past(cpu_wdata_i);
  endproperty
  a_write_seg: assert property (p_write_seg) else $error("segment write lost");

  property p_write_b;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cpu_wr_s2_i && cpu_addr_i == PPSM_ADDR_PORT_B_LATCH |=>
        st.port_b_output_latch == $past(cpu_wdata_i[2:0]);
  endproperty
  a_write_b: assert property (p_write_b) else $error("port b write lost");

  property p_read_levels;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cpu_rd_s1_i && cpu_addr_i == PPSM_ADDR_PORT_A_LEVELS |=>
        cpu_rdata_o == $past(port_a_pin_i);
  endproperty
  a_read_levels: assert property (p_read_levels) else $error("level read wrong");

  property p_read_latch;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cpu_rd_s1_i && cpu_addr_i == PPSM_ADDR_PORT_A_LATCH |=>
        cpu_rdata_o == $past(st.port_a_output_latch);
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("latch read wrong");

  // Read data stands until the next read strobe.
  property p_rdata_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !cpu_rd_s1_i |=> $stable(cpu_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");

  property p_read_b;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cpu_rd_s1_i && cpu_addr_i == PPSM_ADDR_PORT_B_LEVELS |=>
        cpu_rdata_o[2:0] == $past(port_b_pin_i);
  endproperty
  a_read_b: assert property (p_read_b) else $error("port b level read wrong");

  property p_read_b_high;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cpu_rd_s1_i &&
        (cpu_addr_i == PPSM_ADDR_PORT_B_LATCH || cpu_addr_i == PPSM_ADDR_PORT_B_LEVELS) |=>
        cpu_rdata_o[7:3] == 5'h00;
  endproperty
  a_read_b_high: assert property (p_read_b_high) else $error("port b upper bits set");

  property p_latch_drive;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      ((port_a_pin_o ^ st.port_a_output_latch) & ~st.port_a_segment_select) == 8'h00 &&
      ((port_a_pin_oe_o ^ ~st.port_a_output_latch) & ~st.port_a_segment_select) == 8'h00;
  endproperty
  a_latch_drive: assert property (p_latch_drive) else $error("latch drive wrong");

  property p_seg_route;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (port_a_pin_oe_o & st.port_a_segment_select) == st.port_a_segment_select &&
      ((port_a_pin_o ^ segment_drive_i) & st.port_a_segment_select) == 8'h00;
  endproperty
  a_seg_route: assert property (p_seg_route) else $error("segment route wrong");

  property p_stop_float;
    @(posedge ref_clk_i) disable iff (sys_rst_i) stop_mode_i |-> !port_b_pin_oe_o[0];
  endproperty
  a_stop_float: assert property (p_stop_float) else $error("stop pin driven");

  property p_fall;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      $fell(port_b_pin_i[0]) && !$past(sys_rst_i) |=> stop_pin_fall_o;
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");

  // The flag pulses only after a pad fall; reset forces the previous level high.
  property p_fall_only;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      stop_pin_fall_o && !$past(sys_rst_i, 2) |->
        $past(port_b_pin_i[PPSM_STOP_PIN_BIT], 2) && !$past(port_b_pin_i[PPSM_STOP_PIN_BIT]);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("spurious falling edge");

  property p_osc;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      dual_clock_mode_i |->
        port_b_pin_oe_o[2:1] == 2'b10 && port_b_pin_o[2] == slow_crystal_output_i;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator pins wrong");

endmodule
`default_nettype wire

// ==== bench/ppsm_pin_model.sv ====
// Purpose: Board side of the two ports: pull-ups and an optional driver on port A.
// Assumes: Every undriven pad is pulled high; device drive wins over the board driver.
// Notes:   Board levels change only at clock edges, so no chatter reaches the pins.
`timescale 1ns/1ps
`default_nettype none
module ppsm_pin_model (
  input  wire logic [7:0] a_o_i,
  input  wire logic [7:0] a_oe_i,
  input  wire logic [7:0] ext_a_en_i,
  input  wire logic [7:0] ext_a_i,
  input  wire logic [2:0] b_o_i,
  input  wire logic [2:0] b_oe_i,
  output logic      [7:0] a_pin_o,
  output logic      [2:0] b_pin_o
);
  // Released pads read the board driver or the pull-up.
  assign a_pin_o = (a_oe_i & a_o_i) | (~a_oe_i & (~ext_a_en_i | ext_a_i));
  assign b_pin_o = (b_oe_i & b_o_i) | ~b_oe_i;
endmodule
`default_nettype wire

// ==== bench/tb_ppsm_ports.sv ====
// Purpose: Register and pin checks of the dual port block.
// Assumes: Pads are resolved by the pin model.
// Notes: Whole-byte writes only, no read-modify-write.
`timescale 1ns/1ps
`default_nettype none
module tb_ppsm_ports;
  import ppsm_pkg::*;
  logic        ref_clk_i, sys_rst_i, rd_s1, wr_s2, dual, stop, oen, xo, xi, srl, sfall, seen;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, pa_i, pa_o, pa_oe, seg, ext_a, ext_a_en, rv;
  logic [2:0]  pb_i, pb_o, pb_oe;
  int          n_mismatch, checks, cyc;
  ppsm_ports u_ppsm_ports (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cpu_addr_i(addr),
    .cpu_wdata_i(wdata), .cpu_rd_s1_i(rd_s1), .cpu_wr_s2_i(wr_s2), .cpu_rdata_o(rdata),
    .port_a_pin_i(pa_i), .port_a_pin_o(pa_o), .port_a_pin_oe_o(pa_oe), .segment_drive_i(seg),
    .port_b_pin_i(pb_i), .port_b_pin_o(pb_o), .port_b_pin_oe_o(pb_oe), .dual_clock_mode_i(dual),
    .stop_mode_i(stop), .output_drive_enable_i(oen), .slow_crystal_output_i(xo),
    .slow_crystal_input_o(xi), .stop_release_level_o(srl), .stop_pin_fall_o(sfall));
  ppsm_pin_model u_ppsm_pin_model (.a_o_i(pa_o), .a_oe_i(pa_oe), .ext_a_en_i(ext_a_en),
    .ext_a_i(ext_a), .b_o_i(pb_o), .b_oe_i(pb_oe), .a_pin_o(pa_i), .b_pin_o(pb_i));
  task automatic results();
    $display("tests ended: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr_s2 <= 1'b1;
    @(posedge ref_clk_i);
    wr_s2 <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    rd_s1 <= 1'b1;
    @(posedge ref_clk_i);
    rd_s1 <= 1'b0;
    #1;
    d = rdata;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    sys_rst_i <= 1'b1;
    {rd_s1, wr_s2, dual, stop, oen, xo} <= 6'h00;
    addr <= 12'h000;
    wdata <= 8'h00;
    {seg, ext_a, ext_a_en} <= 24'h000000;
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(12'h001, rv);
    chk(rv, 8'hFF);
    rd(12'h029, rv);
    chk(rv, 8'h00);
    rd(12'h002, rv);
    chk({5'h00, rv[2:0]}, 8'h07);
    $display("test reset values done");
    wr(12'h001, 8'h55);
    chk(pa_oe, 8'hAA);
    chk(pa_o & pa_oe, 8'h00);
    rd(12'h001, rv);
    chk(rv, 8'h55);
    rd(12'h008, rv);
    chk(rv, 8'h55);
    wr(12'h001, 8'hFF);
    @(posedge ref_clk_i);
    ext_a_en <= 8'hFF;
    ext_a <= 8'h3C;
    seg <= 8'h05;
    rd(12'h008, rv);
    chk(rv, 8'h3C);
    wr(12'h008, 8'h00);
    rd(12'h001, rv);
    chk(rv, 8'hFF);
    rd(12'h030, rv);
    chk(rv, 8'h00);
    $display("test port A latch and levels done");
    wr(12'h029, 8'h0F);
    chk(pa_oe, 8'h0F);
    chk(pa_o & 8'h0F, 8'h05);
    rd(12'h008, rv);
    chk(rv & 8'hF0, 8'h30);
    wr(12'h029, 8'h00);
    chk(pa_oe, 8'h00);
    $display("test segment routing done");
    @(posedge ref_clk_i);
    oen <= 1'b1;
    wr(12'h002, 8'h00);
    chk({5'h00, pb_oe}, 8'h07);
    @(posedge ref_clk_i);
    {stop, dual, xo} <= 3'h7;
    @(posedge ref_clk_i);
    #1;
    chk({5'h00, pb_oe}, 8'h04);
    chk({7'h00, pb_o[2]}, 8'h01);
    rd(12'h009, rv);
    chk({5'h00, rv[2:0]}, 8'h07);
    chk({7'h00, xi}, 8'h01);
    @(posedge ref_clk_i);
    {stop, dual} <= 2'h0;
    wr(12'h002, 8'h07);
    seen = 1'b0;
    wr(12'h002, 8'h06);
    repeat (4) begin
      @(posedge ref_clk_i);
      #1;
      if (sfall === 1'b1) seen = 1'b1;
    end
    chk({7'h00, seen}, 8'h01);
    chk({7'h00, srl}, 8'h00);
    $display("test port B done");
    results();
  end
endmodule
`default_nettype wire
